// ==== hdl/adr_host_regs.sv ====
// Host-visible control and status registers of the audio decoder
`include "adr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adr_host_regs
   import adr_pkg::*;
#(
   // Arbitrary neutral values, not tied to any real part
   parameter logic [7:0] SILICON_REV = 8'h01,
   parameter logic [7:0] CHIP_ID     = 8'h5a
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Byte access from the serial protocol engine
   input  wire adr_req_t   bus_req,
   output logic [7:0]      bus_rdata,
   output logic            bus_ack,
   // Decoder core status
   input  wire logic       autoboot_done,
   input  wire logic       core_synth_we,
   input  wire logic [7:0] core_synth_mul,
   input  wire logic [7:0] core_synth_div,
   input  wire logic       fault_we,
   input  wire logic [5:0] fault_code,
   input  wire adr_lock_t  lock_state,
   input  wire logic       anc_cnt_we,
   input  wire logic [15:0] anc_cnt,
   input  wire logic       enc_we,
   input  wire logic [4:0] enc_idx,
   input  wire logic [7:0] enc_byte,
   input  wire logic       core_decoding,
   input  wire logic       anc_refill_done,
   // Controls to the clocking, decoder and pins
   output adr_synth_t      synth_ctl,
   output logic [7:0]      synth_mul,
   output logic [7:0]      synth_div,
   output logic            request_invert,
   output logic            sample_on_fall,
   output logic            soft_reset_pulse,
   output logic            play_active,
   output logic            mute_out,
   output logic            mute_clock_run,
   output logic            anc_refill_req,
   output logic            pin_carries_request,
   output adr_dec_state_t  dec_state
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] byte_addr;
   logic [7:0] cur_addr;
   logic [7:0] request_line_polarity;
   logic [7:0] clk_pol;
   logic [7:0] play_reg;
   logic [7:0] mute_reg;
   logic [7:0] anc_cmd;
   logic [7:0] pin_func;
   logic [5:0] fault;
   logic [1:0] lock;
   logic [15:0] anc_count;
   logic [7:0] enc_buf [`ADR_ENC_DEPTH];
   logic       wr_hit;
   logic       soft_hit;

   // Start of transfer loads the sub-address, else use the counter
   assign cur_addr = bus_req.start ? bus_req.addr : byte_addr;
   assign wr_hit   = bus_req.wr;
   assign soft_hit = wr_hit && (cur_addr == `ADR_OFS_SOFT_RST);
   assign bus_ack  = bus_req.wr | bus_req.rd;

   ////////////////////////////////////////////////////////////////////////////
   // Address counter increment
   always_ff @(posedge mclk) begin
      if (rst) begin
         byte_addr <= `ADR_RST_ZERO;
      end else if (bus_req.wr || bus_req.rd) begin
         byte_addr <= cur_addr + 8'h01;
      end else if (bus_req.start) begin
         byte_addr <= bus_req.addr;
      end
   end

   // Soft reset pulse to the core, one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= soft_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock synthesizer control byte
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         synth_ctl <= adr_synth_t'(`ADR_RST_SYNTH_CTL);
      end else if (wr_hit && cur_addr == `ADR_OFS_SYNTH_CTL) begin
         synth_ctl <= adr_synth_t'(bus_req.wdata);
      end else if (autoboot_done) begin
         synth_ctl.fraction_update   <= 1'b1;
         synth_ctl.shared_pin_enable <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         synth_mul <= `ADR_RST_SYNTH_MUL;
      end else if (core_synth_we) begin
         // Core software owns these, so its update wins
         synth_mul <= core_synth_mul;
      end else if (wr_hit && cur_addr == `ADR_OFS_SYNTH_MUL) begin
         synth_mul <= bus_req.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         synth_div <= `ADR_RST_SYNTH_DIV;
      end else if (core_synth_we) begin
         synth_div <= core_synth_div;
      end else if (wr_hit && cur_addr == `ADR_OFS_SYNTH_DIV) begin
         synth_div <= bus_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Polarity registers; request polarity differs between reset kinds
   always_ff @(posedge mclk) begin
      if (rst) begin
         request_line_polarity <= `ADR_HRST_REQUEST_LINE_POLARITY;
      end else if (soft_hit) begin
         request_line_polarity <= `ADR_SRST_REQUEST_LINE_POLARITY;
      end else if (wr_hit && cur_addr == `ADR_OFS_REQUEST_LINE_POLARITY) begin
         request_line_polarity <= bus_req.wdata;
      end
   end

   // Same value after either reset kind
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         clk_pol <= `ADR_RST_CLK_POL;
      end else if (wr_hit && cur_addr == `ADR_OFS_CLK_POL) begin
         clk_pol <= bus_req.wdata;
      end
   end

   assign request_invert = request_line_polarity[`ADR_BIT_REQ_INVERT];
   assign sample_on_fall = clk_pol[`ADR_BIT_CLK_FALL];

   ////////////////////////////////////////////////////////////////////////////
   // Playback, mute, pin function
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         play_reg <= `ADR_RST_PLAY;
      end else if (wr_hit && cur_addr == `ADR_OFS_PLAY) begin
         play_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         mute_reg <= `ADR_RST_ZERO;
      end else if (wr_hit && cur_addr == `ADR_OFS_MUTE) begin
         mute_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         pin_func <= `ADR_RST_ZERO;
      end else if (wr_hit && cur_addr == `ADR_OFS_PIN_FUNC) begin
         pin_func <= bus_req.wdata;
      end
   end

   assign play_active         = play_reg[0] && (dec_state == ADR_DEC_DECODE);
   assign mute_out            = mute_reg[0];
   assign mute_clock_run      = mute_reg[0];
   assign pin_carries_request = pin_func[`ADR_BIT_PIN_REQ];

   // Decoder run state; soft reset returns it to idle
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         dec_state <= ADR_DEC_IDLE;
      end else begin
         unique case (dec_state)
            ADR_DEC_IDLE: begin
               if (autoboot_done) begin
                  dec_state <= ADR_DEC_INIT;
               end
            end
            ADR_DEC_INIT: begin
               if (core_decoding) begin
                  dec_state <= ADR_DEC_DECODE;
               end
            end
            ADR_DEC_DECODE: begin
               if (!core_decoding) begin
                  dec_state <= ADR_DEC_INIT;
               end
            end
            default: begin
               dec_state <= ADR_DEC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refill command, set wins over done
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         anc_cmd <= `ADR_RST_ZERO;
      end else if (wr_hit && cur_addr == `ADR_OFS_ANC_CMD) begin
         anc_cmd <= bus_req.wdata;
      end else if (anc_refill_done) begin
         anc_cmd <= `ADR_RST_ZERO;
      end
   end
   assign anc_refill_req = (anc_cmd != `ADR_RST_ZERO);

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         fault <= 6'h00;
      end else if (fault_we) begin
         fault <= fault_code;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         lock <= ADR_LOCK_SEARCH;
      end else begin
         lock <= lock_state;
      end
   end

   // Count held until the core posts a new frame
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         anc_count <= 16'h0000;
      end else if (anc_cnt_we) begin
         anc_count <= anc_cnt;
      end
   end

   // Encoded sample buffer, zeroed at reset
   always_ff @(posedge mclk) begin
      if (rst || soft_hit) begin
         for (int i = 0; i < `ADR_ENC_DEPTH; i++) begin
            enc_buf[i] <= `ADR_RST_ZERO;
         end
      end else if (enc_we && enc_idx < 5'(`ADR_ENC_DEPTH)) begin
         enc_buf[enc_idx] <= enc_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data; shared offsets give status first, buffer otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_rdata <= `ADR_RST_ZERO;
      end else if (bus_req.rd) begin
         unique case (cur_addr)
            `ADR_OFS_REVISION: begin
               bus_rdata <= SILICON_REV;
            end
            `ADR_OFS_CHIP_ID: begin
               bus_rdata <= CHIP_ID;
            end
            `ADR_OFS_SYNTH_CTL: begin
               bus_rdata <= synth_ctl;
            end
            `ADR_OFS_SYNTH_MUL: begin
               bus_rdata <= synth_mul;
            end
            `ADR_OFS_SYNTH_DIV: begin
               bus_rdata <= synth_div;
            end
            `ADR_OFS_REQUEST_LINE_POLARITY: begin
               bus_rdata <= request_line_polarity;
            end
            `ADR_OFS_CLK_POL: begin
               bus_rdata <= clk_pol;
            end
            `ADR_OFS_FAULT: begin
               bus_rdata <= {2'b00, fault};
            end
            `ADR_OFS_PLAY: begin
               bus_rdata <= play_reg;
            end
            `ADR_OFS_MUTE: begin
               bus_rdata <= mute_reg;
            end
            `ADR_OFS_ANC_CMD: begin
               bus_rdata <= anc_cmd;
            end
            `ADR_OFS_PIN_FUNC: begin
               bus_rdata <= pin_func;
            end
            `ADR_OFS_SYNC: begin
               bus_rdata <= {6'h00, lock};
            end
            `ADR_OFS_ANC_CNT_L: begin
               bus_rdata <= anc_count[7:0];
            end
            `ADR_OFS_ANC_CNT_H: begin
               bus_rdata <= anc_count[15:8];
            end
            default: begin
               if (cur_addr > `ADR_OFS_ANC_CNT_H && cur_addr <= `ADR_OFS_ENC_LAST) begin
                  bus_rdata <= enc_buf[5'(cur_addr - `ADR_OFS_ENC_FIRST)];
               end else begin
                  // Reserved and write-only read as zero
                  bus_rdata <= `ADR_RST_ZERO;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== hdl/adr_defines.svh ====
// Register map, field positions, reset values for the decoder host register bank
// Summary of operation
// - Offset 0x00 returns silicon revision
// - Offset 0x01 returns fixed chip id
// - Control bit 0 loads fractional divider
// - Bit 1 routes crystal to outclk divider
// - Bit 2 routes crystal to core divider
// - Bit 3 disables oscillator output
// - Bit 4 puts system clock on outclk
// - Bit 5 enables outclk pad, resets set
// - Bit 6 disables crystal output pad
// - Bit 7 enables shared pin, autoboot clears
// - Multiplier and divider registers, core owned
// - Request polarity selects request line sense
// - Input clock polarity selects sampling edge
// - Fault register holds last error code
// - Write to 0x10 triggers software reset
// - Play bit acts only while decoding
// - Mute silences output, starts the clock
// - Nonzero write to 0x16 refills ancillary buffer
// - Pin function bit 2 selects shared role
// - Sync state bits report frame lock
// - Encoded sample buffer 0x40 to 0x51, status reads first at 0x40 to 0x42
// - Ancillary count low and high bytes
// - Byte address auto-increments per byte
`ifndef ADR_DEFINES_SVH
`define ADR_DEFINES_SVH

`define ADR_OFS_REVISION     8'h00
`define ADR_OFS_CHIP_ID      8'h01
`define ADR_OFS_SYNTH_CTL    8'h05
`define ADR_OFS_SYNTH_MUL    8'h06
`define ADR_OFS_SYNTH_DIV    8'h07
`define ADR_OFS_REQUEST_LINE_POLARITY      8'h0c
`define ADR_OFS_CLK_POL      8'h0d
`define ADR_OFS_FAULT        8'h0f
`define ADR_OFS_SOFT_RST     8'h10
`define ADR_OFS_PLAY         8'h13
`define ADR_OFS_MUTE         8'h14
`define ADR_OFS_ANC_CMD      8'h16
`define ADR_OFS_PIN_FUNC     8'h18
`define ADR_OFS_ENC_FIRST    8'h40
`define ADR_OFS_ENC_LAST     8'h51
`define ADR_OFS_SYNC         8'h40
`define ADR_OFS_ANC_CNT_L    8'h41
`define ADR_OFS_ANC_CNT_H    8'h42
`define ADR_ENC_DEPTH        18

`define ADR_RST_SYNTH_CTL    8'h21
`define ADR_RST_SYNTH_MUL    8'h0c
`define ADR_RST_SYNTH_DIV    8'h00
`define ADR_HRST_REQUEST_LINE_POLARITY     8'h00
`define ADR_SRST_REQUEST_LINE_POLARITY     8'h01
`define ADR_RST_CLK_POL      8'h04
`define ADR_RST_PLAY         8'h01
`define ADR_RST_ZERO         8'h00
`define ADR_FAULT_MASK       8'h3f

`define ADR_BIT_FRAC_UPD     0
`define ADR_BIT_XTAL_OUTDIV  1
`define ADR_BIT_XTAL_COREDIV 2
`define ADR_BIT_OSC_DIS      3
`define ADR_BIT_SYS_OUTCLK   4
`define ADR_BIT_OUTCLK_EN    5
`define ADR_BIT_XOUT_DIS     6
`define ADR_BIT_SHARED_EN    7
`define ADR_BIT_REQ_INVERT   2
`define ADR_BIT_CLK_FALL     2
`define ADR_BIT_PIN_REQ      2

`endif

// ==== hdl/adr_pkg.sv ====
// Types shared by the decoder host register bank
package adr_pkg;
   typedef enum logic [1:0] {
      ADR_LOCK_SEARCH  = 2'h0,
      ADR_LOCK_CONFIRM = 2'h1,
      ADR_LOCK_SYNCED  = 2'h2
   } adr_lock_t;

   typedef enum logic [1:0] {
      ADR_DEC_IDLE,
      ADR_DEC_INIT,
      ADR_DEC_DECODE
   } adr_dec_state_t;

   // Register port access from the serial protocol engine
   typedef struct packed {
      logic       start;
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } adr_req_t;

   // Clock synthesizer controls decoded from the control byte
   typedef struct packed {
      logic shared_pin_enable;
      logic crystal_out_pad_disable;
      logic outclk_pad_enable;
      logic sysclk_on_outclk;
      logic oscillator_disable;
      logic crystal_feeds_core_divider;
      logic crystal_feeds_outclk_divider;
      logic fraction_update;
   } adr_synth_t;
endpackage

// ==== verification/adr_host_regs_asserts.sv ====
// Port-level checks for the decoder host register bank
`timescale 1ns/1ps
`default_nettype none
module adr_host_regs_asserts
   import adr_pkg::*;
#(
   parameter logic [7:0] SILICON_REV = 8'h01,
   parameter logic [7:0] CHIP_ID     = 8'h5a
) (
   // Clock and reset
   input wire logic           mclk,
   input wire logic           rst,
   // Byte access
   input wire adr_req_t       bus_req,
   input wire logic [7:0]     bus_rdata,
   input wire logic           bus_ack,
   // Core and controls
   input wire logic           autoboot_done,
   input wire adr_synth_t     synth_ctl,
   input wire logic           sample_on_fall,
   input wire logic           soft_reset_pulse,
   input wire logic           play_active,
   input wire logic           mute_out,
   input wire logic           mute_clock_run,
   input wire logic           pin_carries_request,
   input wire adr_dec_state_t dec_state
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   property p_ack;
      bus_ack == (bus_req.wr || bus_req.rd);
   endproperty
   a_ack: assert property (p_ack) else $error("ack mismatch");
   property p_rev;
      bus_req.start && bus_req.rd && bus_req.addr == 8'h00 |=> bus_rdata == SILICON_REV;
   endproperty
   a_rev: assert property (p_rev) else $error("revision read wrong");
   property p_id;
      bus_req.start && bus_req.rd && bus_req.addr == 8'h01 |=> bus_rdata == CHIP_ID;
   endproperty
   a_id: assert property (p_id) else $error("chip id read wrong");
   property p_boot;
      autoboot_done && !bus_req.wr |=> synth_ctl.fraction_update && !synth_ctl.shared_pin_enable;
   endproperty
   a_boot: assert property (p_boot) else $error("autoboot bits wrong");
   property p_clkpol;
      bus_req.start && bus_req.wr && bus_req.addr == 8'h0d
         |=> sample_on_fall == $past(bus_req.wdata[2]);
   endproperty
   a_clkpol: assert property (p_clkpol) else $error("edge select wrong");
   property p_pin;
      bus_req.start && bus_req.wr && bus_req.addr == 8'h18
         |=> pin_carries_request == $past(bus_req.wdata[2]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin role wrong");
   property p_srst;
      bus_req.start && bus_req.wr && bus_req.addr == 8'h10 |=> soft_reset_pulse ##1 !soft_reset_pulse;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
   property p_play;
      play_active |-> dec_state == ADR_DEC_DECODE;
   endproperty
   a_play: assert property (p_play) else $error("play outside decode");
   property p_mute;
      mute_out == mute_clock_run;
   endproperty
   a_mute: assert property (p_mute) else $error("mute clock mismatch");
   c_boot: cover property (autoboot_done);
   c_srst: cover property (soft_reset_pulse);
   c_play: cover property (play_active);
endmodule
bind adr_host_regs adr_host_regs_asserts #(.SILICON_REV(SILICON_REV), .CHIP_ID(CHIP_ID))
   adr_host_regs_asserts_i (.*);
`default_nettype wire

// ==== verification/adr_host_model.sv ====
// Host microcontroller model issuing byte accesses
`timescale 1ns/1ps
`default_nettype none
module adr_host_model
   import adr_pkg::*;
(
   // Clock
   input wire logic       mclk,
   // Byte access
   output var adr_req_t   bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic       bus_ack
);
   initial bus_req = '0;
   task automatic acc(input logic st, input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      @(posedge mclk);
      bus_req <= '{start: st, addr: a, wr: w, rd: !w, wdata: d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (bus_ack !== 1'b1 && n < 20);
      // Idle lines carry junk so stale values never pass
      bus_req <= '{start: 1'b0, addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
      #1 q = bus_rdata;
   endtask
endmodule
`default_nettype wire

// ==== verification/adr_host_regs_bench.sv ====
// Self-checking bench for the decoder host register bank
`timescale 1ns/1ps
`default_nettype none
module adr_host_regs_bench;
   import adr_pkg::*;
   localparam logic [7:0] REV = 8'h3c; // Arbitrary value
   localparam logic [7:0] CID = 8'h96; // Arbitrary value
   logic            mclk, rst, autoboot_done, core_synth_we, fault_we, anc_cnt_we, enc_we;
   logic            core_decoding, anc_refill_done, bus_ack, request_invert, sample_on_fall;
   logic            soft_reset_pulse, play_active, mute_out, mute_clock_run, anc_refill_req;
   logic            pin_carries_request;
   logic [7:0]      core_synth_mul, core_synth_div, enc_byte, bus_rdata, synth_mul, synth_div, q;
   logic [5:0]      fault_code;
   logic [4:0]      enc_idx;
   logic [15:0]     anc_cnt;
   adr_lock_t       lock_state;
   adr_req_t        bus_req;
   adr_synth_t      synth_ctl;
   adr_dec_state_t  dec_state;
   int              fail_count = 0;
   int              checks = 0;
   adr_host_regs #(.SILICON_REV(REV), .CHIP_ID(CID)) adr_host_regs_i (.*);
   adr_host_model adr_host_model_i (.*);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] z;
      adr_host_model_i.acc(1'b1, 1'b1, a, d, z);
   endtask
   task automatic rd(input logic st, input logic [7:0] a);
      adr_host_model_i.acc(st, 1'b0, a, 8'h00, q);
   endtask
   task automatic rd_tab(input logic [7:0] a[$], input logic [7:0] e[$]);
      foreach (a[i]) begin
         rd(1'b1, a[i]);
         chk(q, e[i]);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_tab({8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h0d, 8'h0f, 8'h13, 8'h14, 8'h16,
              8'h18, 8'h40, 8'h41, 8'h42},
             {REV, CID, 8'h21, 8'h0c, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h00});
      chk({synth_ctl, 6'h00, dec_state}, {8'h21, 6'h00, ADR_DEC_IDLE});
      $display("reset values done");
   endtask
   task automatic t_rw();
      wr(8'h05, 8'hde);
      wr(8'h0c, 8'h05);
      wr(8'h0d, 8'h00);
      wr(8'h14, 8'h01);
      wr(8'h16, 8'h01);
      wr(8'h18, 8'h04);
      chk(synth_ctl, 8'hde);
      chk({request_invert, sample_on_fall}, 2'b10);
      chk({mute_out, mute_clock_run, pin_carries_request}, 3'b111);
      chk(anc_refill_req, 1'b1);
      @(posedge mclk);
      anc_refill_done <= 1'b1;
      @(posedge mclk);
      anc_refill_done <= 1'b0;
      #1 chk(anc_refill_req, 1'b0);
      $display("read-write controls done");
   endtask
   task automatic t_ro();
      logic [7:0] a[$] = {8'h00, 8'h01, 8'h0f, 8'h41, 8'h45, 8'h20};
      foreach (a[i]) wr(a[i], 8'hff);
      rd_tab(a, {REV, CID, 8'h00, 8'h00, 8'h00, 8'h00});
      $display("read-only writes done");
   endtask
   task automatic t_core();
      logic [5:0] fc[$] = {6'h01, 6'h02, 6'h04, 6'h10, 6'h2a, 6'h3f};
      foreach (fc[i]) begin
         @(posedge mclk);
         fault_we <= 1'b1;
         fault_code <= fc[i];
         lock_state <= adr_lock_t'(2'(i % 3));
         @(posedge mclk);
         fault_we <= 1'b0;
         rd(1'b1, 8'h0f);
         chk(q, {2'b00, fc[i]});
         rd(1'b1, 8'h40);
         chk(q, {6'h00, 2'(i % 3)});
      end
      @(posedge mclk);
      {anc_cnt_we, enc_we, core_synth_we} <= 3'b111;
      anc_cnt <= 16'h1234;
      {enc_idx, enc_byte} <= {5'd5, 8'h77};
      {core_synth_mul, core_synth_div} <= 16'h3344;
      @(posedge mclk);
      {anc_cnt_we, enc_we, core_synth_we} <= 3'b000;
      rd(1'b0, 8'h00);
      chk(q, 8'h34);
      rd(1'b0, 8'h00);
      chk(q, 8'h12);
      rd(1'b1, 8'h45);
      chk(q, 8'h77);
      rd(1'b1, 8'h06);
      rd(1'b0, 8'h00);
      chk({synth_mul, q}, 16'h3344);
      $display("core status done");
   endtask
   task automatic t_play();
      @(posedge mclk);
      core_decoding <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk({play_active, 6'h00, dec_state}, {1'b0, 6'h00, ADR_DEC_IDLE});
      @(posedge mclk);
      autoboot_done <= 1'b1;
      @(posedge mclk);
      autoboot_done <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk({play_active, 6'h00, dec_state}, {1'b1, 6'h00, ADR_DEC_DECODE});
      chk(synth_ctl, 8'h5f);
      wr(8'h13, 8'h00);
      #1 chk(play_active, 1'b0);
      $display("play and autoboot done");
   endtask
   task automatic t_soft();
      wr(8'h10, 8'h01);
      chk(soft_reset_pulse, 1'b1);
      rd_tab({8'h0c, 8'h05, 8'h13, 8'h14, 8'h16, 8'h18, 8'h0d},
             {8'h01, 8'h21, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04});
      chk(dec_state, ADR_DEC_IDLE);
      $display("soft reset done");
   endtask
   task automatic final_report();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
   initial begin
      rst = 1'b1;
      {autoboot_done, core_synth_we, fault_we, anc_cnt_we, enc_we} = '0;
      {core_decoding, anc_refill_done, fault_code, enc_idx, enc_byte, anc_cnt} = '0;
      {core_synth_mul, core_synth_div, lock_state} = '0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_rw();
      t_ro();
      t_core();
      t_play();
      t_soft();
      final_report();
   end
endmodule
`default_nettype wire
